// file: residual_diff_stage.sv
`timescale 1ns/1ns
module residual_diff_stage #(
   parameter int CYCLE_CLKS = red_pkg::CYCLE_CLKS,
   parameter int REC_DEPTH = red_pkg::REC_DEPTH,
   parameter int CNT_W = red_pkg::CNT_W
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic signed [red_pkg::PH_W-1:0] phase_a_current_re,
   input wire logic signed [red_pkg::PH_W-1:0] phase_a_current_im,
   input wire logic signed [red_pkg::PH_W-1:0] phase_b_current_re,
   input wire logic signed [red_pkg::PH_W-1:0] phase_b_current_im,
   input wire logic signed [red_pkg::PH_W-1:0] phase_c_current_re,
   input wire logic signed [red_pkg::PH_W-1:0] phase_c_current_im,
   input wire logic signed [red_pkg::PH_W-1:0] residual_input_one_re,
   input wire logic signed [red_pkg::PH_W-1:0] residual_input_one_im,
   input wire logic signed [red_pkg::PH_W-1:0] residual_input_two_re,
   input wire logic signed [red_pkg::PH_W-1:0] residual_input_two_im,
   input wire logic block_in,
   input wire logic input_sel,
   input wire logic subtract,
   input wire logic bias_max,
   input wire logic cable_end_mode,
   input wire logic [red_pkg::SET_W-1:0] pickup_set,
   input wire logic [red_pkg::SET_W-1:0] first_turn_point,
   input wire logic [red_pkg::SET_W-1:0] second_turn_point,
   input wire logic [red_pkg::SET_W-1:0] first_slope,
   input wire logic [red_pkg::SET_W-1:0] second_slope,
   input wire logic [red_pkg::GRP_W-1:0] setting_group,
   input wire logic comp_cmd,
   input wire logic store_on_en,
   input wire logic store_off_en,
   input wire logic counter_clear,
   input wire logic [red_pkg::STAMP_W-1:0] timestamp_ms,
   input wire logic [red_pkg::REC_IDX_W-1:0] rec_sel,
   output logic trip_out,
   output logic blocked_out,
   output red_pkg::cond_t condition,
   output logic cycle_tick,
   output logic event_valid,
   output red_pkg::evt_t event_code,
   output logic [red_pkg::STAMP_W-1:0] event_stamp,
   output logic event_store,
   output logic [CNT_W-1:0] trip_count,
   output logic [CNT_W-1:0] block_count,
   output logic [red_pkg::REC_IDX_W-1:0] rec_count,
   output red_pkg::record_t rec_data
);
   char_if ch ();

   logic [31:0] cyc_reg;
   logic tick;
   logic blk_meta_reg, blk_sync_reg;
   logic signed [red_pkg::SUM_W-1:0] comp_re_reg, comp_im_reg;
   red_pkg::cond_t cond_reg, cond_next;
   logic on_pend_reg, off_pend_reg;
   red_pkg::evt_t on_code_reg, off_code_reg;
   logic [red_pkg::VAL_W-1:0] bias_v, diff_v, thr_v;
   logic [red_pkg::VAL_W-1:0] bias_mx_reg, diff_mx_reg, thr_mx_reg;
   logic [red_pkg::VAL_W-1:0] calc_reg, meas_reg, bias_reg, diff_reg;
   logic [red_pkg::VAL_W-1:0] thr_reg;
   red_pkg::record_t rec_mem [REC_DEPTH];
   logic [red_pkg::REC_IDX_W-1:0] wr_ptr_reg;
   logic rec_wr;

   //----------
   // characteristic calculator
   //----------
   assign ch.ph_re[0] = phase_a_current_re;
   assign ch.ph_im[0] = phase_a_current_im;
   assign ch.ph_re[1] = phase_b_current_re;
   assign ch.ph_im[1] = phase_b_current_im;
   assign ch.ph_re[2] = phase_c_current_re;
   assign ch.ph_im[2] = phase_c_current_im;
   assign ch.r1_re = residual_input_one_re;
   assign ch.r1_im = residual_input_one_im;
   assign ch.r2_re = residual_input_two_re;
   assign ch.r2_im = residual_input_two_im;
   assign ch.comp_re = comp_re_reg;
   assign ch.comp_im = comp_im_reg;
   assign ch.input_sel = input_sel;
   assign ch.subtract = subtract;
   assign ch.bias_max = bias_max;
   assign ch.cable_end_mode = cable_end_mode;
   assign ch.pickup_set = pickup_set;
   assign ch.first_turn_point = first_turn_point;
   assign ch.second_turn_point = second_turn_point;
   assign ch.first_slope = first_slope;
   assign ch.second_slope = second_slope;

   residual_char_calc u_calc (
      .c(ch.calc)
   );

   assign bias_v = red_pkg::VAL_W'(ch.bias_mag);
   assign diff_v = red_pkg::VAL_W'(ch.diff_mag);
   assign thr_v = ch.thresh;

   //----------
   // processing cycle and block sampling
   //----------
   always_ff @(posedge ref_clk) begin
      if (srst || cyc_reg == 32'(CYCLE_CLKS - 1)) begin
         cyc_reg <= 32'h0;
      end else begin
         cyc_reg <= cyc_reg + 32'h1;
      end
   end

   assign tick = (cyc_reg == 32'(CYCLE_CLKS - 1));

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cycle_tick <= 1'b0;
      end else begin
         cycle_tick <= tick;
      end
   end

   // block arrives from another source: two stages before use
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         blk_meta_reg <= 1'b0;
         blk_sync_reg <= 1'b0;
      end else begin
         blk_meta_reg <= block_in;
         blk_sync_reg <= blk_meta_reg;
      end
   end

   //----------
   // natural unbalance compensation
   //----------
   // the offset is taken from the uncompensated sum so a repeat is exact
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         comp_re_reg <= '0;
         comp_im_reg <= '0;
      end else if (comp_cmd && cable_end_mode) begin
         comp_re_reg <= ch.calc_re + comp_re_reg;
         comp_im_reg <= ch.calc_im + comp_im_reg;
      end
   end

   //----------
   // stage condition
   //----------
   always_comb begin
      cond_next = red_pkg::COND_NORMAL;
      if (ch.pickup && !blk_sync_reg) begin
         cond_next = red_pkg::COND_TRIP;
      end else if (ch.pickup && blk_sync_reg) begin
         // an active trip drops here exactly as on a pick-up release
         cond_next = red_pkg::COND_BLOCKED;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cond_reg <= red_pkg::COND_NORMAL;
         condition <= red_pkg::COND_NORMAL;
         trip_out <= 1'b0;
         blocked_out <= 1'b0;
      end else if (tick) begin
         cond_reg <= cond_next;
         condition <= cond_next;
         trip_out <= (cond_next == red_pkg::COND_TRIP);
         blocked_out <= (cond_next == red_pkg::COND_BLOCKED);
      end
   end

   //----------
   // trigger values and their maxima
   //----------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         bias_reg <= '0;
         diff_reg <= '0;
         thr_reg <= '0;
         calc_reg <= '0;
         meas_reg <= '0;
         bias_mx_reg <= '0;
         diff_mx_reg <= '0;
         thr_mx_reg <= '0;
      end else if (tick) begin
         bias_reg <= bias_v;
         diff_reg <= diff_v;
         thr_reg <= thr_v;
         calc_reg <= red_pkg::VAL_W'(ch.calc_mag);
         meas_reg <= red_pkg::VAL_W'(ch.meas_mag);
         if (!ch.pickup) begin
            bias_mx_reg <= '0;
            diff_mx_reg <= '0;
            thr_mx_reg <= '0;
         end else begin
            bias_mx_reg <= (bias_v > bias_mx_reg) ? bias_v : bias_mx_reg;
            diff_mx_reg <= (diff_v > diff_mx_reg) ? diff_v : diff_mx_reg;
            thr_mx_reg <= (thr_v > thr_mx_reg) ? thr_v : thr_mx_reg;
         end
      end
   end

   //----------
   // events
   //----------
   // one tick can release one state and enter another: off goes first
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         on_pend_reg <= 1'b0;
         off_pend_reg <= 1'b0;
         on_code_reg <= red_pkg::EVT_TRIP_ON;
         off_code_reg <= red_pkg::EVT_TRIP_OFF;
      end else if (tick) begin
         on_pend_reg <= (cond_next != cond_reg)
            && (cond_next != red_pkg::COND_NORMAL);
         off_pend_reg <= (cond_next != cond_reg)
            && (cond_reg != red_pkg::COND_NORMAL);
         on_code_reg <= (cond_next == red_pkg::COND_BLOCKED) ?
            red_pkg::EVT_BLOCK_ON : red_pkg::EVT_TRIP_ON;
         off_code_reg <= (cond_reg == red_pkg::COND_BLOCKED) ?
            red_pkg::EVT_BLOCK_OFF : red_pkg::EVT_TRIP_OFF;
      end else if (off_pend_reg) begin
         off_pend_reg <= 1'b0;
      end else begin
         on_pend_reg <= 1'b0;
      end
   end

   assign rec_wr = on_pend_reg && !off_pend_reg && !tick;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         event_valid <= 1'b0;
         event_code <= red_pkg::EVT_TRIP_ON;
         event_stamp <= '0;
         event_store <= 1'b0;
      end else if (!tick && (off_pend_reg || on_pend_reg)) begin
         event_valid <= 1'b1;
         event_code <= off_pend_reg ? off_code_reg : on_code_reg;
         event_stamp <= timestamp_ms;
         event_store <= off_pend_reg ? store_off_en : store_on_en;
      end else begin
         event_valid <= 1'b0;
         event_store <= 1'b0;
      end
   end

   //----------
   // counters
   //----------
   // a trip landing on the clear cycle still counts as one
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         trip_count <= '0;
         block_count <= '0;
      end else begin
         if (rec_wr && on_code_reg == red_pkg::EVT_TRIP_ON) begin
            trip_count <= counter_clear ? CNT_W'(1) : trip_count + CNT_W'(1);
         end else if (counter_clear) begin
            trip_count <= '0;
         end
         if (rec_wr && on_code_reg == red_pkg::EVT_BLOCK_ON) begin
            block_count <= counter_clear ? CNT_W'(1) :
               block_count + CNT_W'(1);
         end else if (counter_clear) begin
            block_count <= '0;
         end
      end
   end

   //----------
   // operation records
   //----------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         wr_ptr_reg <= '0;
         rec_count <= '0;
      end else if (rec_wr) begin
         wr_ptr_reg <= (wr_ptr_reg == red_pkg::REC_IDX_W'(REC_DEPTH - 1)) ?
            '0 : wr_ptr_reg + red_pkg::REC_IDX_W'(1);
         if (rec_count != red_pkg::REC_IDX_W'(REC_DEPTH)) begin
            rec_count <= rec_count + red_pkg::REC_IDX_W'(1);
         end
      end
   end

   // memory has no reset: entries beyond rec_count are not meaningful
   always_ff @(posedge ref_clk) begin
      if (rec_wr) begin
         rec_mem[wr_ptr_reg] <= '{stamp: timestamp_ms, code: on_code_reg,
            bias: bias_reg, diff: diff_reg, thresh: thr_reg,
            bias_max: bias_mx_reg, diff_max: diff_mx_reg,
            thresh_max: thr_mx_reg, calc: calc_reg, meas: meas_reg,
            group: setting_group};
      end
   end

   // rec_sel 0 is the newest entry
   always_ff @(posedge ref_clk) begin
      if (srst || rec_sel >= rec_count) begin
         rec_data <= '0;
      end else if (wr_ptr_reg > rec_sel) begin
         rec_data <= rec_mem[wr_ptr_reg - rec_sel - red_pkg::REC_IDX_W'(1)];
      end else begin
         rec_data <= rec_mem[red_pkg::REC_IDX_W'(REC_DEPTH) + wr_ptr_reg
            - rec_sel - red_pkg::REC_IDX_W'(1)];
      end
   end
endmodule

// file: red_pkg.sv
//----------
// Functional notes
//----------
// Functional notes
// - differential is phase sum plus/minus residual
// - bias is average or maximum of magnitudes
// - two-slope threshold above turn points
// - condition shows normal, tripped or blocked
// - block input sampled each processing cycle
// - pick-up without block raises trip
// - pick-up with block raises blocked only
// - block during trip drops trip, releases
// - calculated versus measured residual comparison
// - cable-end mode offers residual difference
// - one store selection for all on events, one for all off events
// - every event carries a time stamp
// - four event codes, trip/block on/off
// - resettable trip and block counters
// - keep twelve newest records, overwrite oldest
// - record holds time, values, maxima, group
// - stage outputs usable directly and by logic
// - compensation nulls calculated residual, cable-end only
// - setting selects residual input one or two
package red_pkg;

   localparam int PH_W = 24;
   localparam int SUM_W = 28;
   localparam int MAG_W = 28;
   localparam int SET_W = 16;
   localparam int VAL_W = 32;
   localparam int WIDE_W = 48;
   localparam int STAMP_W = 48;
   localparam int CNT_W = 16;
   localparam int GRP_W = 3;

   // current units are 0.01 % of nominal; turn points are 0.01 x nominal
   localparam int TP_SCALE = 100;
   // slopes are in 0.01 % steps
   localparam int SLOPE_SCALE = 10000;

   localparam int CLK_HZ = 20000000;
   localparam int CYCLE_TIME_US = 5000;
   localparam int CYCLE_CLKS = CYCLE_TIME_US * (CLK_HZ / 1000000);
   localparam int BLOCK_LEAD_US = 5000;

   localparam int REC_DEPTH = 12;
   localparam int REC_IDX_W = 4;

   typedef enum logic [1:0] {
      COND_NORMAL = 2'h0,
      COND_TRIP = 2'h1,
      COND_BLOCKED = 2'h3
   } cond_t;

   typedef enum logic [1:0] {
      EVT_TRIP_ON = 2'h0,
      EVT_TRIP_OFF = 2'h1,
      EVT_BLOCK_ON = 2'h2,
      EVT_BLOCK_OFF = 2'h3
   } evt_t;

   typedef struct packed {
      logic [STAMP_W-1:0] stamp;
      evt_t code;
      logic [VAL_W-1:0] bias;
      logic [VAL_W-1:0] diff;
      logic [VAL_W-1:0] thresh;
      logic [VAL_W-1:0] bias_max;
      logic [VAL_W-1:0] diff_max;
      logic [VAL_W-1:0] thresh_max;
      logic [VAL_W-1:0] calc;
      logic [VAL_W-1:0] meas;
      logic [GRP_W-1:0] group;
   } record_t;

endpackage

// file: char_if.sv
`timescale 1ns/1ns
interface char_if;
   logic signed [red_pkg::PH_W-1:0] ph_re [3];
   logic signed [red_pkg::PH_W-1:0] ph_im [3];
   logic signed [red_pkg::PH_W-1:0] r1_re, r1_im, r2_re, r2_im;
   logic signed [red_pkg::SUM_W-1:0] comp_re, comp_im;
   logic input_sel, subtract, bias_max, cable_end_mode;
   logic [red_pkg::SET_W-1:0] pickup_set, first_turn_point;
   logic [red_pkg::SET_W-1:0] second_turn_point, first_slope, second_slope;
   logic signed [red_pkg::SUM_W-1:0] calc_re, calc_im;
   logic [red_pkg::MAG_W-1:0] diff_mag, bias_mag, calc_mag, meas_mag;
   logic [red_pkg::VAL_W-1:0] thresh;
   logic pickup;

   modport calc (
      input ph_re, ph_im, r1_re, r1_im, r2_re, r2_im, comp_re, comp_im,
      input input_sel, subtract, bias_max, cable_end_mode,
      input pickup_set, first_turn_point, second_turn_point,
      input first_slope, second_slope,
      output calc_re, calc_im, diff_mag, bias_mag, calc_mag, meas_mag,
      output thresh, pickup
   );
   modport user (
      output ph_re, ph_im, r1_re, r1_im, r2_re, r2_im, comp_re, comp_im,
      output input_sel, subtract, bias_max, cable_end_mode,
      output pickup_set, first_turn_point, second_turn_point,
      output first_slope, second_slope,
      input calc_re, calc_im, diff_mag, bias_mag, calc_mag, meas_mag,
      input thresh, pickup
   );
endinterface

// file: residual_char_calc.sv
`timescale 1ns/1ns
module residual_char_calc (
   char_if.calc c
);
   // magnitude is max + 3/8 min: about 7 % worst error, no multiplier
   function automatic logic [red_pkg::MAG_W-1:0] mag(
      input logic signed [red_pkg::SUM_W-1:0] re,
      input logic signed [red_pkg::SUM_W-1:0] im);
      logic [red_pkg::MAG_W-1:0] a, b, hi, lo;
      a = re[red_pkg::SUM_W-1] ? red_pkg::MAG_W'(-re) : red_pkg::MAG_W'(re);
      b = im[red_pkg::SUM_W-1] ? red_pkg::MAG_W'(-im) : red_pkg::MAG_W'(im);
      hi = (a > b) ? a : b;
      lo = (a > b) ? b : a;
      return hi + (lo >> 2) + (lo >> 3);
   endfunction

   logic signed [red_pkg::SUM_W-1:0] sum_re, sum_im, m_re, m_im;
   logic signed [red_pkg::SUM_W-1:0] d_re, d_im;
   logic [red_pkg::MAG_W-1:0] pa_mag, pb_mag, pc_mag, mx;
   logic [red_pkg::WIDE_W-1:0] bias_w, tp1_w, tp2_w, thr_w;

   //----------
   // phasor sums
   //----------
   always_comb begin
      sum_re = red_pkg::SUM_W'(c.ph_re[0]) + red_pkg::SUM_W'(c.ph_re[1])
         + red_pkg::SUM_W'(c.ph_re[2]);
      sum_im = red_pkg::SUM_W'(c.ph_im[0]) + red_pkg::SUM_W'(c.ph_im[1])
         + red_pkg::SUM_W'(c.ph_im[2]);
      if (c.cable_end_mode) begin
         c.calc_re = sum_re - c.comp_re;
         c.calc_im = sum_im - c.comp_im;
      end else begin
         c.calc_re = sum_re;
         c.calc_im = sum_im;
      end
      m_re = red_pkg::SUM_W'(c.input_sel ? c.r2_re : c.r1_re);
      m_im = red_pkg::SUM_W'(c.input_sel ? c.r2_im : c.r1_im);
      // same-facing transformers must be set to subtract
      if (c.subtract) begin
         d_re = c.calc_re - m_re;
         d_im = c.calc_im - m_im;
      end else begin
         d_re = c.calc_re + m_re;
         d_im = c.calc_im + m_im;
      end
   end

   //----------
   // magnitudes, bias and characteristic
   //----------
   always_comb begin
      c.calc_mag = mag(c.calc_re, c.calc_im);
      c.meas_mag = mag(m_re, m_im);
      c.diff_mag = mag(d_re, d_im);
      pa_mag = mag(red_pkg::SUM_W'(c.ph_re[0]), red_pkg::SUM_W'(c.ph_im[0]));
      pb_mag = mag(red_pkg::SUM_W'(c.ph_re[1]), red_pkg::SUM_W'(c.ph_im[1]));
      pc_mag = mag(red_pkg::SUM_W'(c.ph_re[2]), red_pkg::SUM_W'(c.ph_im[2]));
      mx = (pa_mag > pb_mag) ? pa_mag : pb_mag;
      mx = (pc_mag > mx) ? pc_mag : mx;
      mx = (c.meas_mag > mx) ? c.meas_mag : mx;
      if (c.bias_max) begin
         c.bias_mag = mx;
      end else begin
         c.bias_mag = red_pkg::MAG_W'(({1'b0, c.calc_mag} + c.meas_mag) >> 1);
      end
      bias_w = red_pkg::WIDE_W'(c.bias_mag);
      tp1_w = red_pkg::WIDE_W'(c.first_turn_point) * red_pkg::TP_SCALE;
      tp2_w = red_pkg::WIDE_W'(c.second_turn_point) * red_pkg::TP_SCALE;
      if (bias_w < tp1_w) begin
         thr_w = red_pkg::WIDE_W'(c.pickup_set);
      end else if (bias_w <= tp2_w) begin
         thr_w = red_pkg::WIDE_W'(c.pickup_set) + (bias_w - tp1_w)
            * c.first_slope / red_pkg::SLOPE_SCALE;
      end else begin
         thr_w = red_pkg::WIDE_W'(c.pickup_set) + (bias_w - tp2_w)
            * c.second_slope / red_pkg::SLOPE_SCALE
            + (tp2_w - tp1_w) * c.first_slope / red_pkg::SLOPE_SCALE;
      end
      c.thresh = (thr_w > red_pkg::WIDE_W'({red_pkg::VAL_W{1'b1}})) ?
         {red_pkg::VAL_W{1'b1}} : thr_w[red_pkg::VAL_W-1:0];
      c.pickup = red_pkg::VAL_W'(c.diff_mag) > c.thresh;
   end
endmodule

// file: residual_diff_stage_sva.sv
`timescale 1ns/1ns
//----------
// stage checker
//----------
module residual_diff_stage_sva #(
   parameter int CYCLE_CLKS = red_pkg::CYCLE_CLKS,
   parameter int REC_DEPTH = red_pkg::REC_DEPTH,
   parameter int CNT_W = red_pkg::CNT_W
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic store_on_en,
   input wire logic store_off_en,
   input wire logic counter_clear,
   input wire logic [red_pkg::STAMP_W-1:0] timestamp_ms,
   input wire logic trip_out,
   input wire logic blocked_out,
   input wire red_pkg::cond_t condition,
   input wire logic cycle_tick,
   input wire logic event_valid,
   input wire red_pkg::evt_t event_code,
   input wire logic [red_pkg::STAMP_W-1:0] event_stamp,
   input wire logic event_store,
   input wire logic [CNT_W-1:0] trip_count,
   input wire logic [red_pkg::REC_IDX_W-1:0] rec_count
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (srst);
   logic [31:0] gap_reg;
   logic seen_reg;
   // first tick after reset has no predecessor, so it is not judged
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         gap_reg <= 32'h0;
         seen_reg <= 1'h0;
      end else if (cycle_tick) begin
         gap_reg <= 32'h0;
         seen_reg <= 1'h1;
      end else begin
         gap_reg <= gap_reg + 32'h1;
      end
   end
   sequence trip_on_s;
      event_valid && event_code == red_pkg::EVT_TRIP_ON;
   endsequence
   sequence trip_off_s;
      event_valid && event_code == red_pkg::EVT_TRIP_OFF;
   endsequence
   sequence block_on_s;
      event_valid && event_code == red_pkg::EVT_BLOCK_ON;
   endsequence
   a_trip_flag_match: assert property (
      trip_out == (condition == red_pkg::COND_TRIP))
      else $error("trip flag differs from condition");
   a_block_flag_match: assert property (
      blocked_out == (condition == red_pkg::COND_BLOCKED))
      else $error("blocked flag differs from condition");
   a_cond_on_tick: assert property (
      $changed(condition) |-> cycle_tick)
      else $error("condition moved without a tick");
   a_tick_spacing: assert property (
      cycle_tick && seen_reg |-> gap_reg == CYCLE_CLKS - 1)
      else $error("processing ticks wrongly spaced");
   a_trip_on_state: assert property (
      trip_on_s |-> trip_out)
      else $error("trip on event without trip");
   a_block_on_state: assert property (
      block_on_s |-> blocked_out && !trip_out)
      else $error("block on event without block");
   a_off_then_on: assert property (
      trip_off_s ##0 blocked_out |=> block_on_s)
      else $error("block on did not follow trip off");
   a_event_after_tick: assert property (
      event_valid |-> $past(cycle_tick) || $past(cycle_tick, 2))
      else $error("event outside a tick");
   a_event_stamped: assert property (
      event_valid |-> event_stamp == $past(timestamp_ms))
      else $error("event stamp wrong");
   a_store_select: assert property (
      event_valid |-> event_store == (!event_code[0] ?
         $past(store_on_en) : $past(store_off_en)))
      else $error("event store selection wrong");
   a_trip_count_step: assert property (
      trip_on_s |-> trip_count == ($past(counter_clear) ? 1'h1 :
         $past(trip_count) + 1'h1))
      else $error("trip counter step wrong");
   a_record_bound: assert property (
      rec_count <= REC_DEPTH)
      else $error("record count above depth");
endmodule
bind residual_diff_stage residual_diff_stage_sva #(.CYCLE_CLKS(CYCLE_CLKS),
   .REC_DEPTH(REC_DEPTH), .CNT_W(CNT_W)) i_sva (.*);

// file: ct_blocking_model.sv
`timescale 1ns/1ns
//----------
// measurement channels and blocking matrix
//----------
module ct_blocking_model (
   input wire logic ref_clk,
   input wire logic signed [red_pkg::PH_W-1:0] fault_a,
   input wire logic signed [red_pkg::PH_W-1:0] res_one,
   input wire logic signed [red_pkg::PH_W-1:0] res_two,
   input wire logic block_req,
   output logic signed [red_pkg::PH_W-1:0] phase_a_current_re,
   output logic signed [red_pkg::PH_W-1:0] phase_a_current_im,
   output logic signed [red_pkg::PH_W-1:0] phase_b_current_re,
   output logic signed [red_pkg::PH_W-1:0] phase_b_current_im,
   output logic signed [red_pkg::PH_W-1:0] phase_c_current_re,
   output logic signed [red_pkg::PH_W-1:0] phase_c_current_im,
   output logic signed [red_pkg::PH_W-1:0] residual_input_one_re,
   output logic signed [red_pkg::PH_W-1:0] residual_input_one_im,
   output logic signed [red_pkg::PH_W-1:0] residual_input_two_re,
   output logic signed [red_pkg::PH_W-1:0] residual_input_two_im,
   output logic block_in
);
   // b and c cancel, so the sum equals a but every phase carries current
   always_ff @(posedge ref_clk) begin
      phase_a_current_re <= fault_a;
      phase_b_current_re <= fault_a;
      phase_c_current_re <= -fault_a;
      {phase_a_current_im, phase_b_current_im} <= 48'h0;
      {phase_c_current_im, residual_input_one_im} <= 48'h0;
      residual_input_two_im <= 24'h0;
      residual_input_one_re <= res_one;
      residual_input_two_re <= res_two;
   end
   // follows block_req one clock later
   always_ff @(posedge ref_clk) begin
      block_in <= block_req;
   end
endmodule

// file: residual_diff_stage_test.sv
`timescale 1ns/1ns
module residual_diff_stage_test;
   logic ref_clk, srst, block_in, input_sel, subtract, bias_max, block_req;
   logic cable_end_mode, comp_cmd, store_on_en, store_off_en, counter_clear;
   logic trip_out, blocked_out, cycle_tick, event_valid, event_store;
   logic signed [red_pkg::PH_W-1:0] fault_a, res_one, res_two;
   logic signed [red_pkg::PH_W-1:0] phase_a_current_re, phase_a_current_im;
   logic signed [red_pkg::PH_W-1:0] phase_b_current_re, phase_b_current_im;
   logic signed [red_pkg::PH_W-1:0] phase_c_current_re, phase_c_current_im;
   logic signed [red_pkg::PH_W-1:0] residual_input_one_re;
   logic signed [red_pkg::PH_W-1:0] residual_input_one_im;
   logic signed [red_pkg::PH_W-1:0] residual_input_two_re;
   logic signed [red_pkg::PH_W-1:0] residual_input_two_im;
   logic [red_pkg::SET_W-1:0] pickup_set, first_turn_point;
   logic [red_pkg::SET_W-1:0] second_turn_point, first_slope, second_slope;
   logic [red_pkg::GRP_W-1:0] setting_group;
   logic [red_pkg::STAMP_W-1:0] event_stamp;
   logic [red_pkg::STAMP_W-1:0] timestamp_ms = '0;
   logic [red_pkg::REC_IDX_W-1:0] rec_sel, rec_count;
   logic [red_pkg::CNT_W-1:0] trip_count, block_count;
   red_pkg::cond_t condition;
   red_pkg::evt_t event_code;
   red_pkg::record_t rec_data;
   int errors = 0;
   int cmp_count = 0;
   // short processing cycle keeps the run brief
   residual_diff_stage #(.CYCLE_CLKS(16)) i_dut (.*);
   ct_blocking_model i_far (.*);
   initial begin
      ref_clk = 1'h0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic final_report();
      $display("errors %0d compares %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // timestamp doubles as the hang guard
   always @(posedge ref_clk) begin
      timestamp_ms <= timestamp_ms + 48'h1;
      if (timestamp_ms == 48'hbb8) begin
         errors++;
         final_report();
      end
   end
   task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s exp %h seen %h", name, exp, seen);
      end
   endtask
   task automatic step();
      @(posedge ref_clk);
      while (cycle_tick !== 1'h1) @(posedge ref_clk);
      @(posedge ref_clk);
   endtask
   task automatic drive(logic [23:0] fa, logic [23:0] r1, logic [23:0] r2);
      fault_a <= fa;
      res_one <= r1;
      res_two <= r2;
      step();
   endtask
   task automatic t_trip();
      drive(24'hbb8, 24'h0, 24'h0);
      chk("cond", condition, red_pkg::COND_TRIP);
      chk("ev", {event_valid, event_code}, 3'h4);
      chk("store", event_store, 1'h1);
      repeat (2) @(posedge ref_clk);
      chk("tcnt", trip_count, 16'h1);
      chk("rdiff", rec_data.diff, 32'hbb8);
      chk("rbias", rec_data.bias, 32'h5dc);
      chk("rgrp", rec_data.group, 3'h5);
   endtask
   task automatic t_block();
      block_req <= 1'h1;
      step();
      chk("cond", condition, red_pkg::COND_BLOCKED);
      chk("ev", {event_valid, event_code, event_store}, 4'ha);
      @(posedge ref_clk);
      chk("ev", {event_valid, event_code, event_store}, 4'hd);
      chk("bcnt", block_count, 16'h1);
      store_off_en <= 1'h1;
      block_req <= 1'h0;
      drive(24'h0, 24'h0, 24'h0);
      chk("ev", {event_valid, event_code, event_store}, 4'hf);
      chk("cond", condition, red_pkg::COND_NORMAL);
   endtask
   task automatic t_select();
      subtract <= 1'h1;
      drive(24'hbb8, 24'hbb8, 24'h0);
      chk("ext", condition, red_pkg::COND_NORMAL);
      input_sel <= 1'h1;
      drive(24'hbb8, 24'h0, 24'hbb8);
      chk("sel", condition, red_pkg::COND_NORMAL);
      subtract <= 1'h0;
      drive(24'hbb8, 24'h0, 24'hbb8);
      chk("int", condition, red_pkg::COND_TRIP);
      input_sel <= 1'h0;
      drive(24'h0, 24'h0, 24'h0);
   endtask
   task automatic t_slope();
      bias_max <= 1'h1;
      drive(24'h7530, 24'h0, 24'h0);
      chk("max", condition, red_pkg::COND_NORMAL);
      bias_max <= 1'h0;
      drive(24'h7530, 24'h0, 24'h0);
      chk("avg", condition, red_pkg::COND_TRIP);
      drive(24'h0, 24'h0, 24'h0);
   endtask
   task automatic t_comp();
      cable_end_mode <= 1'h1;
      fault_a <= 24'h7d0;
      repeat (3) @(posedge ref_clk);
      comp_cmd <= 1'h1;
      @(posedge ref_clk);
      comp_cmd <= 1'h0;
      step();
      chk("comp", condition, red_pkg::COND_NORMAL);
      cable_end_mode <= 1'h0;
      drive(24'h7d0, 24'h0, 24'h0);
      chk("nocomp", condition, red_pkg::COND_TRIP);
      drive(24'h0, 24'h0, 24'h0);
   endtask
   task automatic t_records();
      counter_clear <= 1'h1;
      @(posedge ref_clk);
      counter_clear <= 1'h0;
      @(posedge ref_clk);
      chk("clr", {trip_count, block_count}, 32'h0);
      for (int i = 0; i < 13; i++) begin
         drive(24'hbb8, 24'h0, 24'h0);
         drive(24'h0, 24'h0, 24'h0);
      end
      chk("rcnt", rec_count, 4'hc);
      chk("tcnt", trip_count, 16'hd);
   endtask
   initial begin
      srst = 1'h1;
      {block_req, input_sel, subtract, bias_max, cable_end_mode} = 5'h0;
      {comp_cmd, store_off_en, counter_clear} = 3'h0;
      store_on_en = 1'h1;
      {fault_a, res_one, res_two} = 72'h0;
      pickup_set = 16'h3e8;
      first_turn_point = 16'h64;
      second_turn_point = 16'hc8;
      first_slope = 16'h2710;
      second_slope = 16'h61a8;
      setting_group = 3'h5;
      rec_sel = 4'h0;
      repeat (8) @(posedge ref_clk);
      srst <= 1'h0;
      step();
      t_trip();
      t_block();
      t_select();
      t_slope();
      t_comp();
      t_records();
      final_report();
   end
endmodule
